// [include/odt_pkg.sv]
// Shared constants and types of the on/off delay timer pair
package odt_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int BASE_TICK_NS = 10_000_000;
  localparam int BASE_TICK_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
  localparam int SEC_NS = 1_000_000_000;
  localparam int TICKS_PER_SEC = SEC_NS / BASE_TICK_NS;
  localparam int SEC_PER_MIN = 60;
  localparam int MS_PER_TICK = BASE_TICK_NS / 1_000_000;

  // ----------------------------------------------------------------
  // Preset limits
  // ----------------------------------------------------------------
  localparam int PRESET_W = 14;
  localparam int CONST_MAJOR_MAX = 99;
  localparam int CONST_MINOR_MAX_SEC = 99;
  localparam int CONST_MINOR_MAX_MIN = 59;
  localparam int REF_MS_MAX = 99990;
  localparam int REF_SM_MAX = 5999;

  // ----------------------------------------------------------------
  // Timebase codes (constant: s/m/h, reference: ms/s/m)
  // ----------------------------------------------------------------
  localparam logic [1:0] TB_SHORT = 2'h0;
  localparam logic [1:0] TB_MID = 2'h1;
  localparam logic [1:0] TB_LONG = 2'h2;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ON_CONST = 8'h04;
  localparam logic [7:0] ADDR_OFF_CONST = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_ON_TIMER = 8'h10;
  localparam logic [7:0] ADDR_OFF_TIMER = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ON_RETAIN = 0;
  localparam int CTRL_OFF_RETAIN = 1;
  localparam int CTRL_ON_TB = 2;
  localparam int CTRL_OFF_TB = 4;
  localparam int CTRL_ON_REF = 6;
  localparam int CTRL_OFF_REF = 7;
  localparam int CTRL_ON_BLK = 8;
  localparam int CTRL_OFF_BLK = 12;
  localparam int CONST_MINOR = 0;
  localparam int CONST_MAJOR = 8;
  localparam int TIMER_PRESET = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CONST_RST = 32'h0000_0100;

  // ----------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ODT_ON_IDLE = 2'b00,
    ODT_ON_TIMING = 2'b01,
    ODT_ON_SET = 2'b11
  } odt_on_state_t;

  typedef enum logic [1:0] {
    ODT_OFF_IDLE = 2'b00,
    ODT_OFF_HELD = 2'b01,
    ODT_OFF_RUN = 2'b11
  } odt_off_state_t;

endpackage

// [logic/odt_tick_gen.sv]
// Time base: 10 ms, 1 s and 1 min tick pulses
`timescale 1ns/100ps
`default_nettype none
module odt_tick_gen #(
  parameter int TICK_CYCLES = odt_pkg::BASE_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic [2:0] tick
);
  localparam int CW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;

  // A base period below two cycles cannot hold a counter
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [CW-1:0] base_cnt;
    logic [6:0] sec_cnt;
    logic [5:0] min_cnt;
    logic [2:0] tick;
  } odt_tick_st_t;

  odt_tick_st_t st_reg;
  odt_tick_st_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.tick = 3'h0;
    if (st_reg.base_cnt == CW'(TICK_CYCLES - 1)) begin
      st_next.base_cnt = '0;
      st_next.tick[0] = 1'b1;
      if (st_reg.sec_cnt == 7'(odt_pkg::TICKS_PER_SEC - 1)) begin
        st_next.sec_cnt = 7'h0;
        st_next.tick[1] = 1'b1;
        if (st_reg.min_cnt == 6'(odt_pkg::SEC_PER_MIN - 1)) begin
          st_next.min_cnt = 6'h0;
          st_next.tick[2] = 1'b1;
        end else begin
          st_next.min_cnt = st_reg.min_cnt + 6'h1;
        end
      end else begin
        st_next.sec_cnt = st_reg.sec_cnt + 7'h1;
      end
    end else begin
      st_next.base_cnt = st_reg.base_cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule
`default_nettype wire

// [logic/odt_preset.sv]
// Preset resolution: constant or clamped reference value, in ticks
`timescale 1ns/100ps
`default_nettype none
module odt_preset (
  input wire logic src_ref,
  input wire logic [1:0] tb,
  input wire logic [7:0] major,
  input wire logic [7:0] minor,
  input wire logic signed [31:0] ref_value,
  output logic [odt_pkg::PRESET_W-1:0] preset,
  output logic [1:0] tick_sel
);
  logic [31:0] maj;
  logic [31:0] mnr;
  logic [31:0] lim;
  logic [31:0] val;
  logic [1:0] tbc;

  always_comb begin
    // Unused code 3 falls back to the shortest timebase
    tbc = (tb > odt_pkg::TB_LONG) ? odt_pkg::TB_SHORT : tb;
    maj = 32'(major);
    mnr = 32'(minor);
    lim = 32'h0;
    val = 32'h0;
    if (src_ref) begin
      lim = (tbc == odt_pkg::TB_SHORT) ? 32'(odt_pkg::REF_MS_MAX)
                                       : 32'(odt_pkg::REF_SM_MAX);
      if (ref_value < 0) begin
        val = 32'h0;
      end else if (ref_value > $signed(lim)) begin
        val = lim;
      end else begin
        val = ref_value;
      end
      // Milliseconds counted in 10 ms ticks, remainder dropped
      if (tbc == odt_pkg::TB_SHORT) begin
        val = val / 32'(odt_pkg::MS_PER_TICK);
      end
    end else begin
      if (maj > 32'(odt_pkg::CONST_MAJOR_MAX)) begin
        maj = 32'(odt_pkg::CONST_MAJOR_MAX);
      end
      if (tbc == odt_pkg::TB_SHORT) begin
        if (mnr > 32'(odt_pkg::CONST_MINOR_MAX_SEC)) begin
          mnr = 32'(odt_pkg::CONST_MINOR_MAX_SEC);
        end
        val = maj * 32'(odt_pkg::TICKS_PER_SEC) + mnr;
      end else begin
        if (mnr > 32'(odt_pkg::CONST_MINOR_MAX_MIN)) begin
          mnr = 32'(odt_pkg::CONST_MINOR_MAX_MIN);
        end
        val = maj * 32'(odt_pkg::SEC_PER_MIN) + mnr;
      end
    end
    preset = val[odt_pkg::PRESET_W-1:0];
    tick_sel = tbc;
  end
endmodule
`default_nettype wire

// [logic/odt_top.sv]
// On-delay and off-delay timer pair with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - On-delay: trigger rising edge restarts elapsed time from zero.
// - On-delay: trigger held until elapsed reaches preset sets the output.
// - On-delay: trigger falling early clears elapsed time, output stays off.
// - On-delay: output is zero whenever trigger is zero.
// - Retain keeps output and elapsed time over power loss, else defaults.
// - Constant seconds preset limited to 99:99, resolution 10 ms.
// - Constant minutes/hours preset limited to 99:59, resolution 1 s / 1 min.
// - Referenced value counts timebase units, limits 99990 ms, 5999 s or min.
// - Out-of-range referenced value is clamped to nearest valid value.
// - Preset is a constant or another block's value chosen by number.
// - Off-delay: trigger high sets the output at once.
// - Off-delay: falling trigger restarts elapsed; output clears at preset.
// - Off-delay: each new trigger pulse restarts the measurement.
// - Off-delay: clear resets elapsed time and output.
module odt_top #(
  parameter int NBLK = 8,
  parameter int TICK_CYCLES = odt_pkg::BASE_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic on_trig,
  input wire logic off_trig,
  input wire logic off_clear,
  input wire logic power_restore,
  input wire logic [NBLK*32-1:0] blk_value,
  output logic on_q,
  output logic off_q,
  output logic [odt_pkg::PRESET_W-1:0] on_elapsed,
  output logic [odt_pkg::PRESET_W-1:0] off_elapsed
);
  localparam int PW = odt_pkg::PRESET_W;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (NBLK < 1 || NBLK > 16) begin : g_bad_nblk
    $error("NBLK must lie in 1..16");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 2");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic on_retain;
    logic off_retain;
    logic [1:0] on_tb;
    logic [1:0] off_tb;
    logic on_ref;
    logic off_ref;
    logic [3:0] on_blk;
    logic [3:0] off_blk;
    logic [7:0] on_major;
    logic [7:0] on_minor;
    logic [7:0] off_major;
    logic [7:0] off_minor;
    logic dp_write;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    odt_pkg::odt_on_state_t on_state;
    logic [PW-1:0] on_elapsed;
    logic on_q;
    logic on_trig_prev;
    odt_pkg::odt_off_state_t off_state;
    logic [PW-1:0] off_elapsed;
    logic off_q;
  } odt_state_t;

  odt_state_t st_reg;
  odt_state_t st_next;

  // ----------------------------------------------------------------
  // Time base and presets
  // ----------------------------------------------------------------
  logic [2:0] tick;
  logic [PW-1:0] on_preset;
  logic [PW-1:0] off_preset;
  logic [1:0] on_tick_sel;
  logic [1:0] off_tick_sel;
  logic [31:0] on_ref_value;
  logic [31:0] off_ref_value;

  odt_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick)
  );

  // Block numbers of NBLK and above read as zero
  always_comb begin
    on_ref_value = 32'h0;
    off_ref_value = 32'h0;
    if (int'(st_reg.on_blk) < NBLK) begin
      on_ref_value = blk_value[int'(st_reg.on_blk)*32 +: 32];
    end
    if (int'(st_reg.off_blk) < NBLK) begin
      off_ref_value = blk_value[int'(st_reg.off_blk)*32 +: 32];
    end
  end

  odt_preset u_on_preset (
    .src_ref(st_reg.on_ref),
    .tb(st_reg.on_tb),
    .major(st_reg.on_major),
    .minor(st_reg.on_minor),
    .ref_value(on_ref_value),
    .preset(on_preset),
    .tick_sel(on_tick_sel)
  );

  odt_preset u_off_preset (
    .src_ref(st_reg.off_ref),
    .tb(st_reg.off_tb),
    .major(st_reg.off_major),
    .minor(st_reg.off_minor),
    .ref_value(off_ref_value),
    .preset(off_preset),
    .tick_sel(off_tick_sel)
  );

  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  function automatic logic [31:0] read_word(input odt_state_t s, input logic [7:0] addr,
                                             input logic [PW-1:0] onp,
                                             input logic [PW-1:0] offp,
                                             input logic ont, input logic offt);
    logic [31:0] d;
    d = 32'h0;
    case (addr)
      odt_pkg::ADDR_CTRL: begin
        d[odt_pkg::CTRL_ON_RETAIN] = s.on_retain;
        d[odt_pkg::CTRL_OFF_RETAIN] = s.off_retain;
        d[odt_pkg::CTRL_ON_TB +: 2] = s.on_tb;
        d[odt_pkg::CTRL_OFF_TB +: 2] = s.off_tb;
        d[odt_pkg::CTRL_ON_REF] = s.on_ref;
        d[odt_pkg::CTRL_OFF_REF] = s.off_ref;
        d[odt_pkg::CTRL_ON_BLK +: 4] = s.on_blk;
        d[odt_pkg::CTRL_OFF_BLK +: 4] = s.off_blk;
      end
      odt_pkg::ADDR_ON_CONST: begin
        d[odt_pkg::CONST_MINOR +: 8] = s.on_minor;
        d[odt_pkg::CONST_MAJOR +: 8] = s.on_major;
      end
      odt_pkg::ADDR_OFF_CONST: begin
        d[odt_pkg::CONST_MINOR +: 8] = s.off_minor;
        d[odt_pkg::CONST_MAJOR +: 8] = s.off_major;
      end
      odt_pkg::ADDR_STATUS: begin
        d[7:0] = {s.off_state, s.on_state, offt, ont, s.off_q, s.on_q};
      end
      odt_pkg::ADDR_ON_TIMER: begin
        d[PW-1:0] = s.on_elapsed;
        d[odt_pkg::TIMER_PRESET +: PW] = onp;
      end
      odt_pkg::ADDR_OFF_TIMER: begin
        d[PW-1:0] = s.off_elapsed;
        d[odt_pkg::TIMER_PRESET +: PW] = offp;
      end
      default: begin
        d = 32'h0;
      end
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic addr_phase;
  logic on_tick;
  logic off_tick;
  logic [PW-1:0] on_el;
  logic [PW-1:0] off_el;

  always_comb begin
    st_next = st_reg;
    on_el = st_reg.on_elapsed;
    off_el = st_reg.off_elapsed;
    on_tick = tick[on_tick_sel];
    off_tick = tick[off_tick_sel];
    addr_phase = hsel & htrans[1] & hready;

    // Bus slave: zero wait states, word writes only
    st_next.hreadyout = 1'b1;
    st_next.hresp = 1'b0;
    st_next.dp_write = addr_phase & hwrite & (hsize == 3'h2);
    st_next.dp_addr = haddr[7:0];
    if (addr_phase && !hwrite) begin
      st_next.hrdata = read_word(st_reg, haddr[7:0], on_preset, off_preset,
                                 on_trig, off_trig);
    end
    if (st_reg.dp_write) begin
      case (st_reg.dp_addr)
        odt_pkg::ADDR_CTRL: begin
          st_next.on_retain = hwdata[odt_pkg::CTRL_ON_RETAIN];
          st_next.off_retain = hwdata[odt_pkg::CTRL_OFF_RETAIN];
          st_next.on_tb = hwdata[odt_pkg::CTRL_ON_TB +: 2];
          st_next.off_tb = hwdata[odt_pkg::CTRL_OFF_TB +: 2];
          st_next.on_ref = hwdata[odt_pkg::CTRL_ON_REF];
          st_next.off_ref = hwdata[odt_pkg::CTRL_OFF_REF];
          st_next.on_blk = hwdata[odt_pkg::CTRL_ON_BLK +: 4];
          st_next.off_blk = hwdata[odt_pkg::CTRL_OFF_BLK +: 4];
        end
        odt_pkg::ADDR_ON_CONST: begin
          st_next.on_minor = hwdata[odt_pkg::CONST_MINOR +: 8];
          st_next.on_major = hwdata[odt_pkg::CONST_MAJOR +: 8];
        end
        odt_pkg::ADDR_OFF_CONST: begin
          st_next.off_minor = hwdata[odt_pkg::CONST_MINOR +: 8];
          st_next.off_major = hwdata[odt_pkg::CONST_MAJOR +: 8];
        end
        default: begin
          st_next.dp_write = st_next.dp_write;
        end
      endcase
    end

    // On-delay timer
    st_next.on_trig_prev = on_trig;
    if (!on_trig) begin
      on_el = '0;
      st_next.on_state = odt_pkg::ODT_ON_IDLE;
    end else if (!st_reg.on_trig_prev) begin
      on_el = '0;
      st_next.on_state = (on_preset == '0) ? odt_pkg::ODT_ON_SET : odt_pkg::ODT_ON_TIMING;
    end else begin
      case (st_reg.on_state)
        odt_pkg::ODT_ON_TIMING: begin
          if (on_tick && on_el < on_preset) begin
            on_el = on_el + PW'(1);
          end
          if (on_el >= on_preset) begin
            st_next.on_state = odt_pkg::ODT_ON_SET;
          end
        end
        odt_pkg::ODT_ON_SET: begin
          st_next.on_state = odt_pkg::ODT_ON_SET;
        end
        default: begin
          st_next.on_state = odt_pkg::ODT_ON_IDLE;
        end
      endcase
    end
    st_next.on_elapsed = on_el;
    st_next.on_q = on_trig & (st_next.on_state == odt_pkg::ODT_ON_SET);

    // Off-delay timer: clear dominates the trigger
    if (off_clear) begin
      off_el = '0;
      st_next.off_q = 1'b0;
      st_next.off_state = odt_pkg::ODT_OFF_IDLE;
    end else if (off_trig) begin
      off_el = '0;
      st_next.off_q = 1'b1;
      st_next.off_state = odt_pkg::ODT_OFF_HELD;
    end else begin
      case (st_reg.off_state)
        odt_pkg::ODT_OFF_HELD: begin
          off_el = '0;
          st_next.off_state = odt_pkg::ODT_OFF_RUN;
        end
        odt_pkg::ODT_OFF_RUN: begin
          if (off_tick && off_el < off_preset) begin
            off_el = off_el + PW'(1);
          end
          if (off_el >= off_preset) begin
            st_next.off_q = 1'b0;
            st_next.off_state = odt_pkg::ODT_OFF_IDLE;
          end
        end
        default: begin
          st_next.off_state = odt_pkg::ODT_OFF_IDLE;
        end
      endcase
    end
    st_next.off_elapsed = off_el;

    // Power restore: non-retentive timers fall back to defaults
    if (power_restore && !st_reg.on_retain) begin
      st_next.on_elapsed = '0;
      st_next.on_q = 1'b0;
      st_next.on_state = odt_pkg::ODT_ON_IDLE;
      st_next.on_trig_prev = 1'b0;
    end
    if (power_restore && !st_reg.off_retain) begin
      st_next.off_elapsed = '0;
      st_next.off_q = 1'b0;
      st_next.off_state = odt_pkg::ODT_OFF_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.hreadyout <= 1'b1;
      st_reg.on_tb <= odt_pkg::CTRL_RST[odt_pkg::CTRL_ON_TB +: 2];
      st_reg.off_tb <= odt_pkg::CTRL_RST[odt_pkg::CTRL_OFF_TB +: 2];
      st_reg.on_major <= odt_pkg::CONST_RST[odt_pkg::CONST_MAJOR +: 8];
      st_reg.on_minor <= odt_pkg::CONST_RST[odt_pkg::CONST_MINOR +: 8];
      st_reg.off_major <= odt_pkg::CONST_RST[odt_pkg::CONST_MAJOR +: 8];
      st_reg.off_minor <= odt_pkg::CONST_RST[odt_pkg::CONST_MINOR +: 8];
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = st_reg.hreadyout;
  assign hresp = st_reg.hresp;
  assign hrdata = st_reg.hrdata;
  assign on_q = st_reg.on_q;
  assign off_q = st_reg.off_q;
  assign on_elapsed = st_reg.on_elapsed;
  assign off_elapsed = st_reg.off_elapsed;
endmodule
`default_nettype wire

// [sim/odt_src_model.sv]
// Trigger, clear, power and block-value sources for the timer pair
`timescale 1ns/100ps
`default_nettype none
module odt_src_model (
  input wire logic clk_sys,
  input wire logic on_req,
  input wire logic off_req,
  input wire logic clr_req,
  input wire logic pwr_req,
  input wire logic [255:0] val_req,
  output logic on_trig = 1'b0,
  output logic off_trig = 1'b0,
  output logic off_clear = 1'b0,
  output logic power_restore = 1'b0,
  output logic [255:0] blk_value = 256'h0
);
  // Sources move one edge after a request, like a program scan
  always @(posedge clk_sys) begin
    on_trig <= on_req;
    off_trig <= off_req;
    off_clear <= clr_req;
    power_restore <= pwr_req;
    blk_value <= val_req;
  end
endmodule
`default_nettype wire

// [sim/odt_top_sva.sv]
// Timer output checks seen from the top ports
`timescale 1ns/100ps
`default_nettype none
module odt_top_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic on_trig,
  input wire logic off_trig,
  input wire logic off_clear,
  input wire logic power_restore,
  input wire logic on_q,
  input wire logic off_q,
  input wire logic [odt_pkg::PRESET_W-1:0] on_elapsed,
  input wire logic [odt_pkg::PRESET_W-1:0] off_elapsed
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  property p_on_low;
    !on_trig |=> !on_q;
  endproperty
  a_on_low: assert property (p_on_low) else $error("on_q high with trigger low");
  property p_on_rise;
    $rose(on_trig) |=> on_elapsed == '0;
  endproperty
  a_on_rise: assert property (p_on_rise) else $error("on elapsed not restarted");
  property p_on_set;
    $rose(on_q) |-> $past(on_trig);
  endproperty
  a_on_set: assert property (p_on_set) else $error("on_q set without trigger");
  property p_on_keep;
    on_q && on_trig && !power_restore |=> on_q;
  endproperty
  a_on_keep: assert property (p_on_keep) else $error("on_q dropped with trigger");
  property p_off_rise;
    off_trig && !off_clear && !power_restore |=> off_q;
  endproperty
  a_off_rise: assert property (p_off_rise) else $error("off_q not set");
  property p_off_clr;
    off_clear |=> !off_q && off_elapsed == '0;
  endproperty
  a_off_clr: assert property (p_off_clr) else $error("clear ignored");
  property p_on_step;
    $changed(on_elapsed) |-> on_elapsed == $past(on_elapsed) + 14'h1 || on_elapsed == '0;
  endproperty
  a_on_step: assert property (p_on_step) else $error("on elapsed jumped");
  property p_off_step;
    $changed(off_elapsed) |-> off_elapsed == $past(off_elapsed) + 14'h1 || off_elapsed == '0;
  endproperty
  a_off_step: assert property (p_off_step) else $error("off elapsed jumped");
endmodule
bind odt_top odt_top_sva odt_top_sva_i (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .on_trig(on_trig),
  .off_trig(off_trig),
  .off_clear(off_clear),
  .power_restore(power_restore),
  .on_q(on_q),
  .off_q(off_q),
  .on_elapsed(on_elapsed),
  .off_elapsed(off_elapsed)
);
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the on/off delay timer pair
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [2:0] bsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, on_trig, off_trig, off_clear, power_restore, on_q, off_q;
  logic [31:0] hrdata, rd;
  logic [255:0] blk_value;
  logic [odt_pkg::PRESET_W-1:0] on_elapsed, off_elapsed;
  logic on_req = 1'b0, off_req = 1'b0, clr_req = 1'b0, pwr_req = 1'b0;
  logic [255:0] val_req = 256'h0;
  int n_errors = 0;
  int total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  // Short base tick keeps the run brief
  odt_top #(.NBLK(8), .TICK_CYCLES(4)) odt_top_i (.clk_sys(clk_sys), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .on_trig(on_trig), .off_trig(off_trig), .off_clear(off_clear),
    .power_restore(power_restore), .blk_value(blk_value), .on_q(on_q), .off_q(off_q),
    .on_elapsed(on_elapsed), .off_elapsed(off_elapsed));
  odt_src_model odt_src_model_i (.clk_sys(clk_sys), .on_req(on_req), .off_req(off_req),
    .clr_req(clr_req), .pwr_req(pwr_req), .val_req(val_req), .on_trig(on_trig),
    .off_trig(off_trig), .off_clear(off_clear), .power_restore(power_restore),
    .blk_value(blk_value));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic bail(input logic hit);
    if (hit) begin
      chk("wait bound", 32'h0, 32'h1);
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= bsize;
    haddr <= {24'h0, a};
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
    bail(n >= 50);
  endtask
  task automatic wq(input logic off, input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while ((off ? off_q : on_q) !== lvl && n < 2000);
    bail(n >= 2000);
  endtask
  task automatic pwr();
    pwr_req <= 1'b1;
    cyc(1);
    pwr_req <= 1'b0;
    cyc(3);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    bus(0, odt_pkg::ADDR_CTRL, 0);
    chk("ctrl", odt_pkg::CTRL_RST, rd);
    bus(0, odt_pkg::ADDR_ON_CONST, 0);
    chk("on_const", odt_pkg::CONST_RST, rd);
    bus(0, 8'h20, 0);
    chk("unmapped", 32'h0, rd);
    bus(1, odt_pkg::ADDR_ON_CONST, 32'h5);
    // Byte-sized write must leave the preset alone
    bsize = 3'h0;
    bus(1, odt_pkg::ADDR_ON_CONST, 32'h7);
    bsize = 3'h2;
    bus(0, odt_pkg::ADDR_ON_TIMER, 0);
    chk("on preset", 32'h5, {16'h0, rd[31:16]});
    $display("regs done");
  endtask
  task automatic t_on();
    on_req <= 1'b1;
    wq(0, 1);
    chk("on elapsed", 32'h5, 32'(on_elapsed));
    bus(0, odt_pkg::ADDR_STATUS, 0);
    chk("status", 32'h35, rd);
    on_req <= 1'b0;
    cyc(3);
    chk("on low", 32'h0, 32'(on_q));
    on_req <= 1'b1;
    cyc(8);
    on_req <= 1'b0;
    cyc(3);
    chk("on early", 32'h0, 32'(on_elapsed));
    cyc(30);
    chk("on unset", 32'h0, 32'(on_q));
    $display("on-delay done");
  endtask
  task automatic t_off();
    bus(1, odt_pkg::ADDR_OFF_CONST, 32'h6);
    off_req <= 1'b1;
    cyc(3);
    chk("off set", 32'h1, 32'(off_q));
    off_req <= 1'b0;
    cyc(16);
    chk("off held", 32'h1, 32'(off_q));
    off_req <= 1'b1;
    cyc(1);
    off_req <= 1'b0;
    cyc(16);
    chk("off retrig", 32'h1, 32'(off_q));
    wq(1, 0);
    chk("off elapsed", 32'h6, 32'(off_elapsed));
    off_req <= 1'b1;
    cyc(1);
    off_req <= 1'b0;
    cyc(8);
    clr_req <= 1'b1;
    cyc(1);
    clr_req <= 1'b0;
    cyc(3);
    chk("off cleared", 32'h0, 32'(off_q));
    chk("off clr elapsed", 32'h0, 32'(off_elapsed));
    $display("off-delay done");
  endtask
  task automatic t_pre();
    logic [31:0] tc [11] = '{32'h0, 32'h4, 32'h8, 32'h140, 32'h140, 32'h140, 32'h144,
      32'h148, 32'h148, 32'h940, 32'hc};
    logic [31:0] tv [11] = '{32'h0, 32'h0, 32'h0, 32'hf423f, 32'hfffffffb, 32'h39,
      32'h1b58, 32'h1770, 32'h7b, 32'h4d, 32'h4d};
    logic [31:0] te [11] = '{32'h270f, 32'h176f, 32'h176f, 32'h270f, 32'h0, 32'h5,
      32'h176f, 32'h176f, 32'h7b, 32'h0, 32'h270f};
    bus(1, odt_pkg::ADDR_ON_CONST, 32'hc8c8);
    for (int i = 0; i < 11; i++) begin
      val_req[63:32] <= tv[i];
      bus(1, odt_pkg::ADDR_CTRL, tc[i]);
      bus(0, odt_pkg::ADDR_ON_TIMER, 0);
      chk("preset", te[i], {16'h0, rd[31:16]});
    end
    // Off timer: seconds from block 1
    bus(1, odt_pkg::ADDR_CTRL, 32'h1090);
    bus(0, odt_pkg::ADDR_OFF_TIMER, 0);
    chk("off preset", 32'h4d, {16'h0, rd[31:16]});
    $display("presets done");
  endtask
  task automatic t_ret();
    logic [odt_pkg::PRESET_W-1:0] e;
    bus(1, odt_pkg::ADDR_CTRL, 32'h0);
    bus(1, odt_pkg::ADDR_ON_CONST, 32'h50);
    on_req <= 1'b1;
    cyc(40);
    pwr();
    chk("lost elapsed", 32'h1, 32'(on_elapsed < 3));
    bus(1, odt_pkg::ADDR_CTRL, 32'h1);
    cyc(20);
    e = on_elapsed;
    pwr();
    chk("kept elapsed", 32'h1, 32'(on_elapsed >= e && e > 4));
    on_req <= 1'b0;
    $display("retain done");
  endtask
  initial begin
    cyc(2);
    nrst <= 1'b1;
    cyc(3);
    t_regs();
    t_on();
    t_off();
    t_pre();
    t_ret();
    tally_and_finish();
  end
  initial begin
    #400000;
    bail(1'b1);
  end
endmodule
`default_nettype wire
